/* tb_transient_intermittent_earth_fault.sv */
// self-checking bench for the transient intermittent earth fault detector
`timescale 1ns/1ps
`default_nettype none
module tb_transient_intermittent_earth_fault;
  localparam int          SC  = 8;
  localparam logic [31:0] W1N = 32'h0006_7530;
  localparam logic [15:0] VH  = 16'h0400;
  localparam logic [15:0] FL  = 16'h0100;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;} tief_reg_t;
  typedef struct {logic [31:0] w2; logic [31:0] w1; logic signed [15:0] amp; logic onB;
    logic [15:0] vm; logic [15:0] fd; logic [1:0] care; logic [1:0] exp;} tief_det_t;

  logic               sys_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [7:0]         haddr = 8'h00;
  logic [1:0]         htrans = 2'b00;
  logic [2:0]         hsize = 3'b010;
  logic [31:0]        hwdata = 32'h0000_0000;
  logic [31:0]        hrdata;
  logic [31:0]        rd;
  logic               hreadyout;
  logic               hresp;
  logic               blockIn = 1'b1;
  logic               pulseOn = 1'b0;
  logic               onB = 1'b0;
  logic signed [15:0] amp = 16'sh0000;
  logic [15:0]        vLevel = 16'h0000;
  logic [15:0]        fund = 16'h0000;
  logic signed [15:0] curSampleA;
  logic signed [15:0] curSampleB;
  logic signed [15:0] voltSample;
  logic [15:0]        fundPeakA;
  logic [15:0]        fundPeakB;
  logic [15:0]        voltMag;
  logic               startOut;
  logic               tripOut;
  logic               seenS;
  logic               seenT;
  int                 badCount = 0;
  int                 checks = 0;
  int                 cycles = 0;

  // reads of reset values, accepted and refused group writes, sticky error
  tief_reg_t regRows [20] = '{
    '{1'b0, 8'h40, 32'h0008_0002}, '{1'b0, 8'h44, 32'h0006_0014},
    '{1'b0, 8'h48, 32'h0000_000A}, '{1'b0, 8'h70, 32'h0008_0002},
    '{1'b0, 8'h08, 32'h0000_0000}, '{1'b1, 8'h40, 32'h000A_0014},
    '{1'b0, 8'h40, 32'h000A_0014}, '{1'b1, 8'h40, 32'h0009_0014},
    '{1'b1, 8'h40, 32'h0001_0015}, '{1'b0, 8'h40, 32'h000A_0014},
    '{1'b0, 8'h08, 32'h0000_0001}, '{1'b1, 8'h08, 32'h0000_0001},
    '{1'b0, 8'h08, 32'h0000_0000}, '{1'b1, 8'h44, 32'h7530_7530},
    '{1'b1, 8'h44, 32'h0005_0014}, '{1'b0, 8'h44, 32'h7530_7530},
    '{1'b1, 8'h00, 32'h0000_0003}, '{1'b0, 8'h00, 32'h0000_0003},
    '{1'b1, 8'h00, 32'h0000_0000}, '{1'b0, 8'hFC, 32'h0000_0000}};

  // care and exp hold {trip, start}
  tief_det_t detRows [11] = '{
    '{32'h0000_000A, W1N, -16'sh0400, 1'b0, VH, FL, 2'b11, 2'b11},
    '{32'h0000_040A, W1N, -16'sh0400, 1'b0, VH, FL, 2'b11, 2'b00},
    '{32'h0000_040A, W1N, 16'sh0400, 1'b0, VH, FL, 2'b11, 2'b11},
    '{32'h0000_020A, W1N, -16'sh0400, 1'b1, VH, FL, 2'b11, 2'b11},
    '{32'h0000_020A, W1N, -16'sh0400, 1'b0, VH, FL, 2'b11, 2'b00},
    '{32'h0000_000A, W1N, -16'sh0100, 1'b0, VH, FL, 2'b11, 2'b00},
    '{32'h0000_010A, W1N, -16'sh0100, 1'b0, VH, 16'h0080, 2'b11, 2'b11},
    '{32'h0000_000A, W1N, -16'sh0199, 1'b0, VH, FL, 2'b11, 2'b00},
    '{32'h0000_000A, W1N, -16'sh0400, 1'b0, FL, FL, 2'b10, 2'b00},
    '{32'h0000_000A, W1N, -16'sh0400, 1'b0, VH, 16'h0800, 2'b10, 2'b00},
    '{32'h0000_000A, 32'h0006_0001, -16'sh0400, 1'b0, VH, FL, 2'b10, 2'b00}};

  tief_detector #(.SW(16), .SAMPLE_CYCLES(SC)) uut (.sys_clk, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .curSampleA, .curSampleB, .fundPeakA, .fundPeakB, .voltSample, .voltMag, .blockIn,
    .startOut, .tripOut);

  tief_meas_model #(.SC(SC)) meas (.sys_clk, .pulseOn, .amp, .onB, .vLevel, .fund,
    .curSampleA, .curSampleB, .fundPeakA, .fundPeakB, .voltSample, .voltMag);

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  // a hang costs a mismatch and ends the run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      badCount++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // single word transfer; waits on hready rather than assuming a latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : xfer

  // clear through the block input, program group 0, then watch a pulse train
  task automatic run_row(input tief_det_t r);
    blockIn <= 1'b1;
    pulseOn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("start blocked", 1'b0, startOut);
    chk("trip blocked", 1'b0, tripOut);
    xfer(1'b1, 8'h40, 32'h0001_0002, rd);
    xfer(1'b1, 8'h44, r.w1, rd);
    xfer(1'b1, 8'h48, r.w2, rd);
    amp <= r.amp;
    onB <= r.onB;
    vLevel <= r.vm;
    fund <= r.fd;
    blockIn <= 1'b0;
    pulseOn <= 1'b1;
    seenS = 1'b0;
    seenT = 1'b0;
    repeat (1600)
    begin
      @(posedge sys_clk);
      seenS = seenS | startOut;
      seenT = seenT | tripOut;
    end
    if (r.care[0]) chk("start seen", r.exp[0], seenS);
    if (r.care[1]) chk("trip seen", r.exp[1], seenT);
  endtask : run_row

  task automatic final_report();
    $display("checks %0d badCount %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // register table, detection table, then a reset in mid-fault
  initial
  begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk("start at reset", 1'b0, startOut);
    chk("trip at reset", 1'b0, tripOut);
    chk("rdata at reset", 32'h0000_0000, hrdata);
    foreach (regRows[i])
    begin
      xfer(regRows[i].w, regRows[i].a, regRows[i].w ? regRows[i].d : 32'h0000_0000, rd);
      if (!regRows[i].w) chk($sformatf("reg %h", regRows[i].a), regRows[i].d, rd);
    end
    foreach (detRows[i]) run_row(detRows[i]);
    run_row(detRows[0]);
    // trip held for the reset delay once pulses stop, then released without a peak
    pulseOn <= 1'b0;
    repeat (480) @(posedge sys_clk);
    chk("trip held", 1'b1, tripOut);
    repeat (480) @(posedge sys_clk);
    chk("trip released", 1'b0, tripOut);
    chk("start released", 1'b0, startOut);
    // a fresh sequence starts on the next pulse, then reset hits it mid-fault
    pulseOn <= 1'b1;
    repeat (400) @(posedge sys_clk);
    chk("start again", 1'b1, startOut);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk("start after reset", 1'b0, startOut);
    chk("trip after reset", 1'b0, tripOut);
    xfer(1'b0, 8'h40, 32'h0000_0000, rd);
    chk("group word after reset", 32'h0008_0002, rd);
    final_report();
  end
endmodule : tb_transient_intermittent_earth_fault
`default_nettype wire

/* tief_detector.sv */
// transient intermittent earth fault detector with AHB-Lite settings slave
// Operation
// [RULE1] one sample pair every 625 us
// [RULE2] direction from sign and timing, not amplitude
// [RULE3] threshold is normal 0.1 pu or sensitive
// [RULE4] trip needs delay, peaks, voltage, intermittent together
// [RULE5] voltage above pickup on the trip sample
// [RULE6] trip held for settable reset delay
// [RULE7] peak count settable 1 to 20
// [RULE8] operation delay 0.02 to 300 s
// [RULE9] intermittent time 0.01 to 300 s
// [RULE10] operation timer starts at first peak
// [RULE11] short count releases at intermittent timeout
// [RULE12] late last peak trips at once
// [RULE13] intermittent timeout before delay releases stage
// [RULE14] reject delay below peaks times 10 ms
// [RULE15] voltage pickup 1 percent steps, 0.97 dropout
// [RULE16] choose current channel and trip direction
// [RULE17] four setting groups, one active
// [RULE18] peak must exceed fundamental peak to trip
// [RULE19] start indication is its own output
// [RULE20] block input holds the detector inactive
// [RULE21] one count per excursion, re-arm below threshold
// [RULE22] release clears counters, timers and start
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tief_params.svh"
module tief_detector
  import tief_pkg::*;
#(
  parameter int SW            = 16,
  parameter int SAMPLE_CYCLES = `TIEF_SAMPLE_US * `TIEF_CLK_MHZ
)(
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic signed [SW-1:0] curSampleA,
  input  wire logic signed [SW-1:0] curSampleB,
  input  wire logic        [SW-1:0] fundPeakA,
  input  wire logic        [SW-1:0] fundPeakB,
  input  wire logic signed [SW-1:0] voltSample,
  input  wire logic        [SW-1:0] voltMag,
  input  wire logic                 blockIn,
  output logic                      startOut,
  output logic                      tripOut
);

  localparam int DW = $clog2(SAMPLE_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(SAMPLE_CYCLES - 1);
  localparam int TW = 20;

  ////////////////////////////////////////////////////////////////////////////
  // sample rate

  logic [DW-1:0] sampleDiv;
  logic          sampleStrobe;
  logic          stepNow;

  // one strobe per sample interval
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sampleDiv    <= '0;
      sampleStrobe <= 1'b0;
      stepNow      <= 1'b0;
    end
    else
    begin
      sampleDiv    <= (sampleDiv == DIV_LAST) ? '0 : sampleDiv + 1'b1; // [RULE1]
      sampleStrobe <= (sampleDiv == DIV_LAST); // [RULE1]
      stepNow      <= sampleStrobe; // result cycle, aligned with peakHit
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings

  logic [31:0]  setMem [4][3];
  tief_group_t  activeGroup;
  logic         rejectFlag;
  logic [4:0]   peaksSet;
  logic [13:0]  opSet;
  logic [14:0]  intSet;
  logic [14:0]  rstSet;
  logic [5:0]   pctSet;
  logic         sensSet;
  logic         chbSet;
  logic         revSet;

  // fields of the active group
  always_comb
  begin
    peaksSet = setMem[activeGroup][0][`TIEF_PEAKS_LSB +: 5]; // [RULE17]
    opSet    = setMem[activeGroup][0][`TIEF_OPDLY_LSB +: 14];
    intSet   = setMem[activeGroup][1][`TIEF_INT_LSB +: 15];
    rstSet   = setMem[activeGroup][1][`TIEF_RST_LSB +: 15];
    pctSet   = setMem[activeGroup][2][`TIEF_PCT_LSB +: 6];
    sensSet  = setMem[activeGroup][2][`TIEF_SENS_BIT];
    chbSet   = setMem[activeGroup][2][`TIEF_CHB_BIT];
    revSet   = setMem[activeGroup][2][`TIEF_REV_BIT];
  end

  // range check of a group word; a bad word is refused whole
  function automatic logic wordOk(input logic [1:0] w, input logic [31:0] d);
    logic [4:0]  pk;
    logic [13:0] op;
    logic [14:0] it;
    logic [14:0] rs;
    logic [5:0]  pc;
    pk = d[`TIEF_PEAKS_LSB +: 5];
    op = d[`TIEF_OPDLY_LSB +: 14];
    it = d[`TIEF_INT_LSB +: 15];
    rs = d[`TIEF_RST_LSB +: 15];
    pc = d[`TIEF_PCT_LSB +: 6];
    case (w)
      2'd0: wordOk = pk >= 5'd1 && pk <= 5'(`TIEF_PEAKS_MAX) // [RULE7]
                     && op >= 14'd1 && op <= 14'(`TIEF_OPDLY_MAX) // [RULE8]
                     && {op, 1'b0} >= 15'(pk); // [RULE14]
      2'd1: wordOk = it >= 15'd1 && it <= 15'(`TIEF_INT_MAX) // [RULE9]
                     && rs >= 15'(`TIEF_RST_MIN) && rs <= 15'(`TIEF_RST_MAX); // [RULE6]
      2'd2: wordOk = pc >= 6'd1 && pc <= 6'(`TIEF_PCT_MAX); // [RULE15]
      default: wordOk = 1'b0;
    endcase
  endfunction : wordOk

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  logic       dpWrite;
  logic [7:0] dpAddr;
  logic       addrPhase;
  logic       grpHit;
  logic       grpWordOk;

  assign addrPhase = hsel && hready && htrans[1];
  assign grpHit    = dpAddr[7:6] == `TIEF_GRP_REGION && dpAddr[3:2] != 2'd3;
  assign grpWordOk = wordOk(dpAddr[3:2], hwdata);

  // address phase capture
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dpWrite <= 1'b0;
      dpAddr  <= '0;
    end
    else
    begin
      dpWrite <= addrPhase && hwrite;
      dpAddr  <= haddr;
    end
  end

  // response is always ready and OKAY
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // group memory and active group writes
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      activeGroup <= '0;
      for (int g = 0; g < 4; g++)
      begin
        setMem[g][0] <= `TIEF_W0_RESET;
        setMem[g][1] <= `TIEF_W1_RESET;
        setMem[g][2] <= `TIEF_W2_RESET;
      end
    end
    else if (dpWrite)
    begin
      if (dpAddr == `TIEF_OFS_CTRL)
        activeGroup <= hwdata[1:0]; // [RULE17]
      else if (grpHit && grpWordOk)
        case (dpAddr[3:2])
          2'd0: setMem[dpAddr[5:4]][0] <= hwdata & `TIEF_W0_MASK;
          2'd1: setMem[dpAddr[5:4]][1] <= hwdata & `TIEF_W1_MASK;
          default: setMem[dpAddr[5:4]][2] <= hwdata & `TIEF_W2_MASK;
        endcase
    end
  end

  // sticky refusal flag; a new refusal beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rejectFlag <= 1'b0;
    else if (dpWrite && grpHit && !grpWordOk)
      rejectFlag <= 1'b1; // [RULE14]
    else if (dpWrite && dpAddr == `TIEF_OFS_ERROR && hwdata[0])
      rejectFlag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // peak detection and residual voltage

  logic peakHit;
  logic aboveFund;
  logic voltOk;

  tief_peak_det #(
    .SW (SW)
  ) u_peak (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .sampleStrobe (sampleStrobe),
    .curSample    (chbSet ? curSampleB : curSampleA), // [RULE16]
    .voltSample   (voltSample),
    .fundPeak     (chbSet ? fundPeakB : fundPeakA), // [RULE18]
    .sensitive    (sensSet),
    .reverse      (revSet),
    .peakHit      (peakHit),
    .aboveFund    (aboveFund)
  );

  logic [31:0] voltScaled;
  logic [31:0] pickScaled;

  // scaled by the ratio denominator so the 0.97 dropout stays integer
  assign voltScaled = 32'(voltMag) * 32'(`TIEF_HYST_DEN) * 32'(`TIEF_HYST_DEN);
  assign pickScaled = 32'(pctSet) * 32'(`TIEF_VOLT_NOM) * 32'(`TIEF_HYST_DEN);

  // voltage condition with hysteresis, updated per sample
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      voltOk <= 1'b0;
    else if (sampleStrobe && !voltOk && voltScaled > pickScaled)
      voltOk <= 1'b1; // [RULE15]
    else if (sampleStrobe && voltOk
             && voltScaled < pickScaled / 32'(`TIEF_HYST_DEN) * 32'(`TIEF_HYST_NUM))
      voltOk <= 1'b0; // [RULE15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence: start, timers, trip and release

  tief_state_t   state;
  tief_state_t   next_state;
  logic [TW-1:0] opTimer;
  logic [TW-1:0] intTimer;
  logic [TW-1:0] rstTimer;
  logic [4:0]    peakCount;
  logic          transSeen;
  logic [TW-1:0] opLim;
  logic [TW-1:0] intLim;
  logic [TW-1:0] rstLim;
  logic [4:0]    next_peakCount;
  logic          next_transSeen;
  logic          opDone;
  logic          intDone;
  logic          rstDone;

  // settings turned into sample counts
  assign opLim  = TW'(32'(opSet) * `TIEF_SAMPLES_20MS);
  assign intLim = TW'(32'(intSet) * `TIEF_SAMPLES_10MS);
  assign rstLim = TW'(32'(rstSet) * `TIEF_SAMPLES_10MS);

  // decisions are taken in the result cycle of every sample, so timeouts need no peak
  always_comb
  begin
    next_peakCount = (peakHit && peakCount != 5'h1F) ? peakCount + 1'b1 : peakCount;
    next_transSeen = transSeen || (peakHit && aboveFund); // [RULE18]
    opDone         = opTimer + 1'b1 >= opLim;
    intDone        = !peakHit && intTimer + 1'b1 >= intLim;
    rstDone        = !(peakHit && voltOk) && rstTimer + 1'b1 >= rstLim;
    next_state     = state;
    case (state)
      ST_IDLE:
        if (peakHit)
          next_state = ST_RUN; // [RULE10]
      ST_RUN:
        if (opDone && next_peakCount >= peaksSet && voltOk && next_transSeen)
          next_state = ST_TRIP; // [RULE4] [RULE5] [RULE12]
        else if (intDone)
          next_state = ST_IDLE; // [RULE11] [RULE13]
      ST_TRIP:
        if (rstDone)
          next_state = ST_IDLE; // [RULE6]
      default:
        next_state = ST_IDLE;
    endcase
  end

  // state register; block input forces release at any time
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || blockIn)
      state <= ST_IDLE; // [RULE20]
    else if (stepNow)
      state <= next_state;
  end

  // timers run one count per sample, evaluated on the delayed hit cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || blockIn || (stepNow && next_state == ST_IDLE && state != ST_IDLE))
    begin
      opTimer   <= '0; // [RULE22]
      intTimer  <= '0;
      rstTimer  <= '0;
      peakCount <= '0;
      transSeen <= 1'b0;
    end
    else if (stepNow && state == ST_IDLE)
    begin
      peakCount <= peakHit ? 5'd1 : 5'd0; // [RULE10]
      transSeen <= peakHit && aboveFund;
    end
    else if (stepNow && state == ST_RUN)
    begin
      opTimer   <= opTimer + 1'b1; // [RULE10]
      intTimer  <= peakHit ? '0 : intTimer + 1'b1;
      peakCount <= next_peakCount;
      transSeen <= next_transSeen;
    end
    else if (stepNow && state == ST_TRIP)
      rstTimer  <= (peakHit && voltOk) ? '0 : rstTimer + 1'b1; // [RULE6]
  end

  // outputs follow the state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || blockIn)
    begin
      startOut <= 1'b0; // [RULE20]
      tripOut  <= 1'b0;
    end
    else if (stepNow)
    begin
      startOut <= next_state != ST_IDLE; // [RULE19] [RULE22]
      tripOut  <= next_state == ST_TRIP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  logic [31:0] statusWord;

  assign statusWord = {14'h0, activeGroup, 3'h0, peakCount, 4'h0,
                       blockIn, voltOk, tripOut, startOut};

  // read data prepared in the address phase so hrdata is a flip-flop
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      hrdata <= '0;
    else if (addrPhase && !hwrite)
    begin
      if (haddr == `TIEF_OFS_CTRL)
        hrdata <= {30'h0, activeGroup};
      else if (haddr == `TIEF_OFS_STATUS)
        hrdata <= statusWord;
      else if (haddr == `TIEF_OFS_ERROR)
        hrdata <= {31'h0, rejectFlag};
      else if (haddr[7:6] == `TIEF_GRP_REGION && haddr[3:2] != 2'd3)
        hrdata <= setMem[haddr[5:4]][haddr[3:2]];
      else
        hrdata <= '0;
    end
  end

endmodule : tief_detector
`default_nettype wire

/* tief_detector_sva.sv */
// port checker for the transient intermittent earth fault detector
`timescale 1ns/1ps
`default_nettype none
module tief_detector_sva #(
  parameter int SW = 16
)(
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 hsel,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic                 hready,
  input  wire logic [31:0]          hrdata,
  input  wire logic                 hreadyout,
  input  wire logic                 hresp,
  input  wire logic signed [SW-1:0] curSampleA,
  input  wire logic signed [SW-1:0] curSampleB,
  input  wire logic        [SW-1:0] voltMag,
  input  wire logic                 blockIn,
  input  wire logic                 startOut,
  input  wire logic                 tripOut
);
  logic bigCur;

  // any current beyond the sensitive level on either channel
  always_comb
  begin
    bigCur = (curSampleA > 16'sh00CD) || (curSampleA < -16'sh00CD) ||
             (curSampleB > 16'sh00CD) || (curSampleB < -16'sh00CD);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  AST_READY: assert property (hreadyout) else $error("hreadyout low");
  AST_OKAY: assert property (!hresp) else $error("hresp not okay");
  AST_BLOCK: assert property (blockIn[*2] |-> !startOut && !tripOut)
    else $error("output high while blocked");
  AST_TRIP_START: assert property (tripOut |-> startOut)
    else $error("trip without start");
  AST_POST_RESET: assert property ($fell(sys_rst) |-> !startOut && !tripOut && hrdata == 0)
    else $error("outputs not cleared by reset");
  AST_TRIP_VOLT: assert property ($rose(tripOut) |-> $past(voltMag, 2) > 16'h0027)
    else $error("trip with no residual voltage");
  AST_START_CAUSE: assert property ($rose(startOut) |->
    $past(bigCur, 2) || $past(bigCur, 3))
    else $error("start without a current peak");
  AST_TRIP_LATE: assert property ($rose(tripOut) |-> $past(startOut))
    else $error("trip before start");
  AST_RDATA_HOLD: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
    |-> $stable(hrdata))
    else $error("read data moved without a read");
endmodule : tief_detector_sva

bind tief_detector tief_detector_sva #(.SW(SW)) chk (.sys_clk, .sys_rst, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .curSampleA, .curSampleB, .voltMag,
  .blockIn, .startOut, .tripOut);
`default_nettype wire

/* tief_meas_model.sv */
// sampled residual current and voltage channels feeding the detector
`timescale 1ns/1ps
`default_nettype none
module tief_meas_model #(
  parameter int SC = 8
)(
  input  wire logic               sys_clk,
  input  wire logic               pulseOn,
  input  wire logic signed [15:0] amp,
  input  wire logic               onB,
  input  wire logic        [15:0] vLevel,
  input  wire logic        [15:0] fund,
  output logic signed      [15:0] curSampleA,
  output logic signed      [15:0] curSampleB,
  output logic             [15:0] fundPeakA,
  output logic             [15:0] fundPeakB,
  output logic signed      [15:0] voltSample,
  output logic             [15:0] voltMag
);
  int   phase = 0;
  logic hi;

  // free phase, unrelated to the strobe: two samples high then 22 low, so
  // every pulse is seen by a strobe, the gap re-arms the counter and a short
  // intermittent time can run out between two pulses
  always @(posedge sys_clk)
  begin
    phase <= (phase + 1) % (24 * SC);
  end

  // the unselected channel stays quiet
  assign hi         = pulseOn && (phase < 2 * SC);
  assign curSampleA = (hi && !onB) ? amp : 16'sh0000;
  assign curSampleB = (hi && onB) ? amp : 16'sh0000;
  assign fundPeakA  = fund;
  assign fundPeakB  = fund;
  assign voltSample = 16'sh0300; // positive residual voltage, sign sets direction
  assign voltMag    = vLevel;
endmodule : tief_meas_model
`default_nettype wire

/* tief_params.svh */
// constants of the transient intermittent earth fault detector
`ifndef TIEF_PARAMS_SVH
`define TIEF_PARAMS_SVH

// timing
`define TIEF_CLK_MHZ        250
`define TIEF_SAMPLE_US      625
`define TIEF_PEAK_SPACE_MS  10
`define TIEF_SAMPLES_10MS   ((`TIEF_PEAK_SPACE_MS * 1000) / `TIEF_SAMPLE_US)
`define TIEF_SAMPLES_20MS   (2 * `TIEF_SAMPLES_10MS)

// fixed current thresholds, nominal voltage and dropout ratio, 1 pu = 16'h1000
`define TIEF_THR_NORMAL     16'h0199
`define TIEF_THR_SENS       16'h00CD
`define TIEF_VOLT_NOM       16'h1000
`define TIEF_HYST_NUM       97
`define TIEF_HYST_DEN       100

// register byte offsets
`define TIEF_OFS_CTRL       8'h00
`define TIEF_OFS_STATUS     8'h04
`define TIEF_OFS_ERROR      8'h08
`define TIEF_GRP_REGION     2'b01

// group word 0: peaks and operation delay (20 ms units)
`define TIEF_PEAKS_LSB      0
`define TIEF_OPDLY_LSB      16
`define TIEF_W0_MASK        32'h3FFF_001F
`define TIEF_W0_RESET       32'h0008_0002
// group word 1: intermittent and reset delay (10 ms units)
`define TIEF_INT_LSB        0
`define TIEF_RST_LSB        16
`define TIEF_W1_MASK        32'h7FFF_7FFF
`define TIEF_W1_RESET       32'h0006_0014
// group word 2: voltage pickup percent, sensitive, channel b, reverse
`define TIEF_PCT_LSB        0
`define TIEF_SENS_BIT       8
`define TIEF_CHB_BIT        9
`define TIEF_REV_BIT        10
`define TIEF_W2_MASK        32'h0000_073F
`define TIEF_W2_RESET       32'h0000_000A

// setting limits
`define TIEF_PEAKS_MAX      20
`define TIEF_OPDLY_MAX      15000
`define TIEF_INT_MAX        30000
`define TIEF_RST_MIN        6
`define TIEF_RST_MAX        30000
`define TIEF_PCT_MAX        60

`endif

/* tief_peak_det.sv */
// directional peak detector for one residual current sample stream
`timescale 1ns/1ps
`default_nettype none
`include "tief_params.svh"
module tief_peak_det
  import tief_pkg::*;
#(
  parameter int SW = 16
)(
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 sampleStrobe,
  input  wire logic signed [SW-1:0] curSample,
  input  wire logic signed [SW-1:0] voltSample,
  input  wire logic        [SW-1:0] fundPeak,
  input  wire logic                 sensitive,
  input  wire logic                 reverse,
  output logic                      peakHit,
  output logic                      aboveFund
);

  logic [SW:0] curMag;
  logic [SW:0] thr;
  logic        above;
  logic        inDir;
  logic        armed;

  // magnitude one bit wider so the most negative code cannot wrap
  always_comb
  begin
    curMag = curSample[SW-1] ? (SW+1)'(-{curSample[SW-1], curSample})
                             : {1'b0, curSample};
    thr    = sensitive ? (SW+1)'(`TIEF_THR_SENS) : (SW+1)'(`TIEF_THR_NORMAL);
    above  = curMag > thr; // [RULE3]
    // forward fault current opposes the residual voltage; size plays no part
    inDir  = (curSample[SW-1] ^ voltSample[SW-1]) ^ reverse; // [RULE2] [RULE16]
  end

  // one count per excursion, re-armed only below threshold
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      armed <= 1'b1;
    else if (sampleStrobe && !above)
      armed <= 1'b1; // [RULE21]
    else if (sampleStrobe && inDir)
      armed <= 1'b0; // [RULE21]
  end

  // hit pulse and fundamental comparison, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      peakHit   <= 1'b0;
      aboveFund <= 1'b0;
    end
    else
    begin
      peakHit   <= sampleStrobe && above && armed && inDir; // [RULE21]
      aboveFund <= curMag > {1'b0, fundPeak}; // [RULE18]
    end
  end

endmodule : tief_peak_det
`default_nettype wire

/* tief_pkg.sv */
// types of the transient intermittent earth fault detector
package tief_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIP} tief_state_t;
  typedef logic [1:0] tief_group_t;

endpackage : tief_pkg
